/* File: acr_top.sv */
// Execute-mailbox interpreter for configuration report and command register wrap.
// Assumes an AHB-Lite master, a single clock, and a host that polls or takes hostIrq.
//
// What this block does
// - Report command writes configuration block after mailbox
// - Report runs by itself after every reset
// - Block holds 32-bit base for all offsets
// - Mailbox offsets at 6, 8 and A
// - Statistics counters offset is reported
// - Offset of last RAM byte is reported
// - Memory size reported in kilobytes
// - Descriptor region size at offset 10
// - Transmit list start at offset 12
// - Transmit descriptor count at offset 14
// - Receive list start at offset 16
// - Receive descriptor count at offset 18
// - Firmware revision at offset 1A
// - Controller statistics at 1E, 1C reserved
// - Wrap echoes every command value back
// - Echo raises interrupt when host enable set
// - Wrap ends only on nrst or on attention plus reset
// - Host interrupted by command register writes, report finishes and wrap echoes
`timescale 1ns/1ns
`default_nettype none
`include "acr_regs.svh"
module acr_top #(
  parameter logic [31:0] BASE_OFFSET     = 32'h0000_0000,
  parameter logic [15:0] RX_MBOX_OFF     = 16'h0100,
  parameter logic [15:0] TX_MBOX_OFF     = 16'h0110,
  parameter logic [15:0] EX_MBOX_OFF     = 16'h0120,
  parameter logic [15:0] STATS_OFF       = 16'h0200,
  parameter logic [15:0] MEM_KBYTES      = 16'h0040,
  parameter logic [15:0] BD_REGION_BYTES = 16'h2000,
  parameter logic [15:0] TX_LIST_START   = 16'h4000,
  parameter logic [15:0] TX_LIST_COUNT   = 16'h0080,
  parameter logic [15:0] RX_LIST_START   = 16'h5000,
  parameter logic [15:0] RX_LIST_COUNT   = 16'h0080,
  parameter logic [15:0] FW_REVISION     = 16'h0001,
  parameter logic [15:0] CTRL_STATS_OFF  = 16'h0300,
  parameter int          PRAM_DEPTH      = 32
) (
  input  wire logic        sys_clk,   // 100 MHz system clock
  input  wire logic        nrst,      // Synchronous reset, active low
  input  wire logic        hsel,      // AHB slave select
  input  wire logic [31:0] haddr,     // AHB byte address
  input  wire logic [1:0]  htrans,    // AHB transfer type
  input  wire logic        hwrite,    // AHB write
  input  wire logic [2:0]  hsize,     // AHB size
  input  wire logic [31:0] hwdata,    // AHB write data
  output logic      [31:0] hrdata,    // AHB read data
  output logic             hreadyout, // AHB ready
  output logic             hresp,     // AHB response
  output logic             hostIrq    // Level interrupt to the host
);
  localparam int AW = $clog2(PRAM_DEPTH);
  // Last byte of RAM follows from the memory size
  localparam logic [31:0] MEM_BYTES   = {16'h0000, MEM_KBYTES} << 10;
  localparam logic [15:0] END_RAM_OFF = 16'(MEM_BYTES - 32'h0000_0001);

  acr_pkg::acr_state_t state_ff;
  acr_pkg::acr_state_t nxt_state;
  logic [AW-1:0]  idx_ff;
  logic [15:0]    code_ff;
  logic           err_ff;
  logic           wrap_ff;
  logic           auto_ff;
  logic [15:0]    cmdIn_ff;
  logic           cmdPend_ff;
  logic [15:0]    cmdOut_ff;
  logic           hostIrqEn_ff;
  logic           softRst_ff;
  logic [`ACR_IRQ_W-1:0] irqStat_ff;
  logic [`ACR_IRQ_W-1:0] irqEn_ff;
  logic [`ACR_IRQ_W-1:0] nxt_irqStat;
  logic [15:0]    paRdata;
  logic [15:0]    pbRdata;

  acr_bus_if bus ();

  acr_ahb_slave u_slave (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .bus       (bus.slave)
  );

  // Contents of one block word, keyed by printed byte offset
  function automatic logic [15:0] blkWord(input logic [5:0] off);
    case (off)
      `ACR_BLK_BASE_LO:    blkWord = BASE_OFFSET[15:0];
      `ACR_BLK_BASE_HI:    blkWord = BASE_OFFSET[31:16];
      `ACR_BLK_RX_MBOX:    blkWord = RX_MBOX_OFF;
      `ACR_BLK_TX_MBOX:    blkWord = TX_MBOX_OFF;
      `ACR_BLK_EX_MBOX:    blkWord = EX_MBOX_OFF;
      `ACR_BLK_STATS:      blkWord = STATS_OFF;
      `ACR_BLK_MEM_KB:     blkWord = MEM_KBYTES;
      `ACR_BLK_BD_REGION:  blkWord = BD_REGION_BYTES;
      `ACR_BLK_TX_START:   blkWord = TX_LIST_START;
      `ACR_BLK_TX_COUNT:   blkWord = TX_LIST_COUNT;
      `ACR_BLK_RX_START:   blkWord = RX_LIST_START;
      `ACR_BLK_RX_COUNT:   blkWord = RX_LIST_COUNT;
      `ACR_BLK_FW_REV:     blkWord = FW_REVISION;
      `ACR_BLK_CTRL_STATS: blkWord = CTRL_STATS_OFF;
      `ACR_BLK_END_RAM:    blkWord = END_RAM_OFF;
      default:             blkWord = 16'h0000;           // Reserved word at 1C
    endcase
  endfunction

  // Register decode on the data phase of a write
  wire        rstAll     = !nrst || softRst_ff;
  wire        wrCmdIn    = bus.wr && (bus.addr == `ACR_ADDR_CMD_IN);
  wire        wrHostCtrl = bus.wr && (bus.addr == `ACR_ADDR_HOST_CTRL);
  wire        wrIrqClr   = bus.wr && (bus.addr == `ACR_ADDR_IRQ_CLR);
  wire        wrIrqEn    = bus.wr && (bus.addr == `ACR_ADDR_IRQ_EN);
  wire [8:0]  pramEnd    = 9'(`ACR_ADDR_PRAM) + 9'(4 * PRAM_DEPTH);
  wire        inPram     = (bus.addr >= `ACR_ADDR_PRAM) && ({1'b0, bus.addr} < pramEnd);
  wire [AW-1:0] paAddr   = AW'(bus.addr[7:2] - 6'h10);
  wire        paWe       = bus.wr && inPram;
  // Both bits in one write are needed; attention alone does nothing here
  wire        hostReset  = wrHostCtrl && hwdataBit(`ACR_HC_HOST_ATTENTION_BIT_BIT)
                           && hwdataBit(`ACR_HC_RESET_BIT);

  function automatic logic hwdataBit(input int pos);
    hwdataBit = bus.wdata[pos];
  endfunction

  // Engine decode of the mailbox command word
  wire [15:0] mbCode     = pbRdata & `ACR_CODE_MASK;
  wire        isReport   = (mbCode == `ACR_CODE_REPORT);
  wire        isWrap     = (mbCode == `ACR_CODE_WRAP);
  wire        takeCmd    = (state_ff == acr_pkg::ST_IDLE) && cmdPend_ff;
  wire        echoNow    = takeCmd && wrap_ff;
  wire        execNow    = takeCmd && !wrap_ff;
  wire        ackNow     = (state_ff == acr_pkg::ST_ACK);
  wire        cmdWrite   = echoNow || ackNow;

  // Engine port of the parameter RAM
  wire        pbWe       = (state_ff == acr_pkg::ST_REPORT) || (state_ff == acr_pkg::ST_FINISH);
  wire [AW-1:0] pbAddr   = (state_ff == acr_pkg::ST_REPORT) ? idx_ff : '0;
  wire [15:0] doneWord   = code_ff | (16'h0001 << `ACR_MB_DONE_BIT)
                           | (err_ff ? (16'h0001 << `ACR_MB_ERR_BIT) : 16'h0000);
  wire [15:0] pbWdata    = (state_ff == acr_pkg::ST_REPORT) ? blkWord(6'({idx_ff, 1'b0}))
                           : doneWord;

  acr_param_ram #(.DEPTH(PRAM_DEPTH), .WIDTH(16), .AW(AW)) u_pram (
    .sys_clk (sys_clk),
    .aWe     (paWe),
    .aAddr   (paAddr),
    .aWdata  (bus.wdata[15:0]),
    .aRdata  (paRdata),
    .bWe     (pbWe),
    .bAddr   (pbAddr),
    .bWdata  (pbWdata),
    .bRdata  (pbRdata)
  );

  // Read mux; unmapped addresses read as zero
  wire [31:0] stateWord  = {27'h000_0000, auto_ff, wrap_ff, state_ff};
  assign bus.rdata =
      inPram                                   ? {16'h0000, paRdata} :
      (bus.addr == `ACR_ADDR_CMD_IN)           ? {16'h0000, cmdIn_ff} :
      (bus.addr == `ACR_ADDR_CMD_OUT)          ? {16'h0000, cmdOut_ff} :
      (bus.addr == `ACR_ADDR_HOST_CTRL)        ? {31'h0000_0000, hostIrqEn_ff} :
      (bus.addr == `ACR_ADDR_IRQ_STAT)         ? {29'h0000_0000, irqStat_ff} :
      (bus.addr == `ACR_ADDR_IRQ_EN)           ? {29'h0000_0000, irqEn_ff} :
      (bus.addr == `ACR_ADDR_STATE)            ? stateWord :
                                                 32'h0000_0000;

  // Engine sequencing: fetch the code, fill the block, mark the header done, acknowledge
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      acr_pkg::ST_IDLE:   if (execNow) nxt_state = acr_pkg::ST_FETCH;
      acr_pkg::ST_FETCH:  nxt_state = isReport ? acr_pkg::ST_REPORT : acr_pkg::ST_FINISH;
      acr_pkg::ST_REPORT: if (idx_ff == `ACR_BLK_LAST_IDX) nxt_state = acr_pkg::ST_FINISH;
      acr_pkg::ST_FINISH: nxt_state = auto_ff ? acr_pkg::ST_IDLE : acr_pkg::ST_ACK;
      acr_pkg::ST_ACK:    nxt_state = acr_pkg::ST_IDLE;
      default:            nxt_state = acr_pkg::ST_IDLE;
    endcase
  end

  // Any reset restarts the report without a host request
  always_ff @(posedge sys_clk) begin
    if (rstAll) begin
      state_ff <= acr_pkg::ST_REPORT;
      idx_ff   <= AW'(1);
      code_ff  <= `ACR_CODE_REPORT;
      auto_ff  <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= (state_ff == acr_pkg::ST_REPORT) ? idx_ff + AW'(1) : AW'(1);
      if (state_ff == acr_pkg::ST_FETCH) code_ff <= mbCode;
      if (execNow) auto_ff <= 1'b0;
    end
  end

  // Unknown codes complete with the error bit; wrap latches until a reset
  always_ff @(posedge sys_clk) begin
    if (rstAll) begin
      err_ff  <= 1'b0;
      wrap_ff <= 1'b0;
    end else if (state_ff == acr_pkg::ST_FETCH) begin
      err_ff  <= !isReport && !isWrap;
      if (isWrap) wrap_ff <= 1'b1;
    end
  end

  // Host command word; a write landing as the old one is taken is kept
  always_ff @(posedge sys_clk) begin
    if (rstAll) begin
      cmdIn_ff   <= 16'h0000;
      cmdPend_ff <= 1'b0;
    end else begin
      if (wrCmdIn) cmdIn_ff <= bus.wdata[15:0];
      cmdPend_ff <= wrCmdIn || (cmdPend_ff && !takeCmd);
    end
  end

  // Command-out register: echo in wrap, acknowledge otherwise
  always_ff @(posedge sys_clk) begin
    if (rstAll) cmdOut_ff <= 16'h0000;
    else if (echoNow) cmdOut_ff <= cmdIn_ff;
    else if (ackNow) cmdOut_ff <= `ACR_ACK_EXEC;
  end

  // Host control survives the adapter reset it requests
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hostIrqEn_ff <= 1'b0;
      softRst_ff   <= 1'b0;
      irqEn_ff     <= '0;
    end else begin
      if (wrHostCtrl) hostIrqEn_ff <= bus.wdata[`ACR_HC_IRQ_EN_BIT];
      softRst_ff <= hostReset;
      if (wrIrqEn) irqEn_ff <= bus.wdata[`ACR_IRQ_W-1:0];
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_comb begin
    nxt_irqStat = irqStat_ff & ~(wrIrqClr ? bus.wdata[`ACR_IRQ_W-1:0] : '0);
    if (cmdWrite) nxt_irqStat[`ACR_IRQ_CMD_BIT] = 1'b1;
    if (echoNow) nxt_irqStat[`ACR_IRQ_WRAP_BIT] = 1'b1;
    if (state_ff == acr_pkg::ST_FINISH && code_ff == `ACR_CODE_REPORT)
      nxt_irqStat[`ACR_IRQ_RPT_BIT] = 1'b1;
  end

  // Command-register event needs the host-side enable as well
  wire [`ACR_IRQ_W-1:0] irqGate = {{(`ACR_IRQ_W-1){1'b1}}, hostIrqEn_ff};
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irqStat_ff <= '0;
      hostIrq    <= 1'b0;
    end else begin
      irqStat_ff <= nxt_irqStat;
      hostIrq    <= |(irqStat_ff & irqEn_ff & irqGate);
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rstAll);

  wire [5:0] pbOff = {1'b0, pbAddr} << 1;

  autoReport_a: assert property ($fell(rstAll) |-> ##[1:20] (pbWe && pbAddr == '0
                  && pbWdata[`ACR_MB_DONE_BIT]))
    else $error("report did not finish after reset");
  reportLen_a: assert property ((state_ff == acr_pkg::ST_REPORT && idx_ff == AW'(1))
                 |-> ##16 (state_ff == acr_pkg::ST_FINISH))
    else $error("block fill took the wrong number of cycles");
  baseWords_a: assert property ((pbWe && state_ff == acr_pkg::ST_REPORT && pbOff == 6'h02)
                 |=> (pbOff == 6'h04 && pbWdata == BASE_OFFSET[31:16]
                 && $past(pbWdata) == BASE_OFFSET[15:0]))
    else $error("base offset words out of place");
  mboxOffs_a: assert property ((state_ff == acr_pkg::ST_REPORT && pbOff == 6'h06)
                |-> pbWdata == RX_MBOX_OFF ##1 pbWdata == TX_MBOX_OFF ##1 pbWdata == EX_MBOX_OFF)
    else $error("mailbox offsets wrong");
  statsOff_a: assert property ((state_ff == acr_pkg::ST_REPORT && pbOff == 6'h0C)
                |-> pbWdata == STATS_OFF ##1 pbWdata == MEM_KBYTES)
    else $error("statistics or size word wrong");
  memSize_a: assert property ((state_ff == acr_pkg::ST_REPORT && pbOff == 6'h0E)
               |-> ##9 (pbOff == 6'h20 && pbWdata == END_RAM_OFF))
    else $error("memory size or end of RAM wrong");
  listWords_a: assert property ((state_ff == acr_pkg::ST_REPORT && pbOff == 6'h10)
                 |-> pbWdata == BD_REGION_BYTES ##1 pbWdata == TX_LIST_START
                 ##1 pbWdata == TX_LIST_COUNT ##1 pbWdata == RX_LIST_START
                 ##1 pbWdata == RX_LIST_COUNT)
    else $error("descriptor list words wrong");
  fwTail_a: assert property ((state_ff == acr_pkg::ST_REPORT && pbOff == 6'h1A)
              |-> pbWdata == FW_REVISION ##1 pbWdata == 16'h0000 ##1 pbWdata == CTRL_STATS_OFF)
    else $error("revision, reserved or controller statistics wrong");
  echoVal_a: assert property (echoNow |=> cmdOut_ff == $past(cmdIn_ff)
               && irqStat_ff[`ACR_IRQ_CMD_BIT])
    else $error("wrap did not echo the command value");
  echoIrq_a: assert property ((echoNow && hostIrqEn_ff && irqEn_ff[`ACR_IRQ_CMD_BIT]
               && !wrIrqClr && !wrHostCtrl && !wrIrqEn) |-> ##2 hostIrq)
    else $error("echo did not raise the interrupt");
  wrapHold_a: assert property ((wrap_ff && !hostReset) |=> wrap_ff)
    else $error("wrap mode dropped without a reset");
  irqCause_a: assert property ($rose(irqStat_ff[`ACR_IRQ_CMD_BIT])
                |-> $past(cmdWrite))
    else $error("command interrupt without a command register write");

  // Acknowledge, auto-run silence, report flag, error completion, wrap entry and wrap idle hold
  ackCode_a: assert property (ackNow |=> cmdOut_ff == `ACR_ACK_EXEC)
    else $error("acknowledge code not written");
  autoQuiet_a: assert property ((state_ff == acr_pkg::ST_FINISH && auto_ff)
                 |=> $stable(cmdOut_ff))
    else $error("automatic report wrote the command register");
  reportIrq_a: assert property ((state_ff == acr_pkg::ST_FINISH
                 && code_ff == `ACR_CODE_REPORT) |=> irqStat_ff[`ACR_IRQ_RPT_BIT])
    else $error("report finish not flagged");
  errWord_a: assert property ((state_ff == acr_pkg::ST_FETCH && !isReport && !isWrap)
               |=> (pbWe && pbWdata[`ACR_MB_ERR_BIT]) ##1 ackNow)
    else $error("unknown code not completed with error");
  wrapEntry_a: assert property ((state_ff == acr_pkg::ST_FETCH && isWrap)
                 |=> wrap_ff)
    else $error("wrap code did not enter wrap mode");
  wrapIdle_a: assert property ((wrap_ff && state_ff == acr_pkg::ST_IDLE)
                |=> state_ff == acr_pkg::ST_IDLE)
    else $error("engine left idle in wrap mode");
  // The pin stays low while every enabled path is shut
  irqGate_a: assert property ((!hostIrqEn_ff && irqEn_ff[`ACR_IRQ_W-1:1] == '0)
              |=> !hostIrq)
    else $error("interrupt raised with the host enable off");

  // Scenarios the bench should reach
  reportCmd_c: cover property (execNow ##1 (state_ff == acr_pkg::ST_FETCH && isReport));
  wrapEcho_c:  cover property (echoNow ##[1:20] echoNow);
  errCode_c:   cover property (state_ff == acr_pkg::ST_FINISH && err_ff);
  irqOut_c:    cover property ($rose(hostIrq));
  softRst_c:   cover property (hostReset);
endmodule
`default_nettype wire

/* File: acr_regs.svh */
// Register map, field positions and fixed codes of the configuration report block.
// Assumes a 32-bit AHB-Lite register window with byte addresses in its low 8 bits.
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH
// Register byte addresses
`define ACR_ADDR_CMD_IN     8'h00
`define ACR_ADDR_CMD_OUT    8'h04
`define ACR_ADDR_HOST_CTRL  8'h08
`define ACR_ADDR_IRQ_STAT   8'h0C
`define ACR_ADDR_IRQ_CLR    8'h10
`define ACR_ADDR_IRQ_EN     8'h14
`define ACR_ADDR_STATE      8'h18
`define ACR_ADDR_PRAM       8'h40
// Host control bits
`define ACR_HC_IRQ_EN_BIT   0
`define ACR_HC_HOST_ATTENTION_BIT_BIT     1
`define ACR_HC_RESET_BIT    2
// Interrupt status bits
`define ACR_IRQ_CMD_BIT     0
`define ACR_IRQ_RPT_BIT     1
`define ACR_IRQ_WRAP_BIT    2
`define ACR_IRQ_W           3
// Execute codes and mailbox header bits
`define ACR_CODE_REPORT     16'h0006
`define ACR_CODE_WRAP       16'h0007
`define ACR_CODE_MASK       16'h1FFF
`define ACR_MB_DONE_BIT     15
`define ACR_MB_ERR_BIT      13
`define ACR_ACK_EXEC        16'h0008
// Configuration block byte offsets and last word index
`define ACR_BLK_BASE_LO     6'h02
`define ACR_BLK_BASE_HI     6'h04
`define ACR_BLK_RX_MBOX     6'h06
`define ACR_BLK_TX_MBOX     6'h08
`define ACR_BLK_EX_MBOX     6'h0A
`define ACR_BLK_STATS       6'h0C
`define ACR_BLK_MEM_KB      6'h0E
`define ACR_BLK_BD_REGION   6'h10
`define ACR_BLK_TX_START    6'h12
`define ACR_BLK_TX_COUNT    6'h14
`define ACR_BLK_RX_START    6'h16
`define ACR_BLK_RX_COUNT    6'h18
`define ACR_BLK_FW_REV      6'h1A
`define ACR_BLK_RESERVED    6'h1C
`define ACR_BLK_CTRL_STATS  6'h1E
`define ACR_BLK_END_RAM     6'h20
`define ACR_BLK_LAST_IDX    5'h10
`endif

/* File: acr_pkg.sv */
// Types shared by the configuration report block.
// Assumes nothing beyond a SystemVerilog compiler.
package acr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH  = 3'b001,
    ST_REPORT = 3'b010,
    ST_FINISH = 3'b011,
    ST_ACK    = 3'b100
  } acr_state_t;
endpackage

/* File: acr_bus_if.sv */
// Internal register access path from the AHB slave to the block.
// Assumes one slave and one target on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface acr_bus_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave  (output wr, output addr, output wdata, input rdata);
  modport target (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: acr_ahb_slave.sv */
// AHB-Lite slave front end: one wait state on reads, none on writes, always OKAY.
// Assumes it is the only slave, so its own hreadyout is the bus ready.
`timescale 1ns/1ns
`default_nettype none
module acr_ahb_slave (
  input  wire logic        sys_clk,   // System clock
  input  wire logic        nrst,      // Synchronous reset, active low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [2:0]  hsize,     // Transfer size
  input  wire logic [31:0] hwdata,    // Write data
  output logic      [31:0] hrdata,    // Read data
  output logic             hreadyout, // Transfer done
  output logic             hresp,     // Always OKAY
  acr_bus_if.slave         bus        // Access path into the block
);
  logic [7:0] addr_ff;
  logic       wrPend_ff;
  logic       rdPend_ff;

  // Address phase qualification; only whole-word writes land
  wire accept = hsel && htrans[1] && hreadyout;
  wire isWord = (hsize == 3'b010);

  // Capture the address phase
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      addr_ff   <= 8'h00;
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
    end else begin
      if (accept) addr_ff <= haddr[7:0];
      wrPend_ff <= accept && hwrite && isWord;
      rdPend_ff <= accept && !hwrite;
    end
  end

  // Reads stall one cycle so that hrdata comes from a flop
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !(accept && !hwrite);
      if (rdPend_ff) hrdata <= bus.rdata;
      hresp     <= 1'b0;
    end
  end

  assign bus.wr    = wrPend_ff;
  assign bus.addr  = addr_ff;
  assign bus.wdata = hwdata;
endmodule
`default_nettype wire

/* File: acr_param_ram.sv */
// Two-port parameter RAM holding the execute mailbox and the configuration block.
// Assumes port B (the engine) wins when both ports write the same word.
`timescale 1ns/1ns
`default_nettype none
module acr_param_ram #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 16,
  parameter int AW    = 5
) (
  input  wire logic             sys_clk, // System clock
  input  wire logic             aWe,     // Host port write
  input  wire logic [AW-1:0]    aAddr,   // Host port word index
  input  wire logic [WIDTH-1:0] aWdata,  // Host port write data
  output logic      [WIDTH-1:0] aRdata,  // Host port read data
  input  wire logic             bWe,     // Engine port write
  input  wire logic [AW-1:0]    bAddr,   // Engine port word index
  input  wire logic [WIDTH-1:0] bWdata,  // Engine port write data
  output logic      [WIDTH-1:0] bRdata   // Engine port read data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Asynchronous reads keep the engine's fetch to one cycle
  assign aRdata = mem[aAddr];
  assign bRdata = mem[bAddr];

  // Engine write is last, so it overrides a colliding host write
  always_ff @(posedge sys_clk) begin
    if (aWe) mem[aAddr] <= aWdata;
    if (bWe) mem[bAddr] <= bWdata;
  end
endmodule
`default_nettype wire

/* File: acr_host_model.sv */
// Host driver model: an AHB-Lite master that plays the host side.
// Assumes one slave whose hreadyout is the bus ready, one clock.
`timescale 1ns/1ns
`default_nettype none
module acr_host_model (
  input  wire logic        sys_clk,  // System clock
  input  wire logic        hready,   // Bus ready
  input  wire logic [31:0] hrdata,   // Read data
  output logic             hsel,     // Slave select
  output logic      [31:0] haddr,    // Byte address
  output logic      [1:0]  htrans,   // Transfer type
  output logic             hwrite,   // Write when high
  output logic      [2:0]  hsize,    // Always a word
  output logic      [31:0] hwdata,   // Write data
  output logic             hangSeen  // A wait ran out
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    hangSeen = 1'b0;
  end
  // Bounded wait, so a stuck slave is flagged instead of hanging the run
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) hangSeen <= 1'b1;
  endtask
  // One single word transfer; signals move only just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk);
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    waitReady();
    htrans <= 2'b00;
    hwdata <= d;
    waitReady();
    q = hrdata;
    hwdata <= ~d; // Released data never shows the last value
  endtask
endmodule
`default_nettype wire

/* File: acr_top_tb.sv */
// Self-checking bench: report after reset, report command, wrap and its end.
// Assumes the host model as the only bus master.
`timescale 1ns/1ns
`default_nettype none
`include "acr_regs.svh"
module acr_top_tb;
  // Block contents set here; word 16 is end of RAM for 32 KB
  localparam logic [15:0] EXP [1:16] = '{16'h1234, 16'h0005, 16'h0100, 16'h0110,
    16'h0120, 16'h0200, 16'h0020, 16'h1000, 16'h2000, 16'h0040, 16'h3000,
    16'h0040, 16'h0003, 16'h0000, 16'h0300, 16'h7FFF};
  localparam logic [15:0] ECHO [4] = '{16'hFFFF, 16'hA5A5, 16'h5A5A, 16'h0001};
  logic sys_clk, nrst, hsel, hwrite, hready, hresp, hostIrq, hangSeen;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          miscompares = 0;
  int          n_compared = 0;
  acr_top #(.BASE_OFFSET({EXP[2], EXP[1]}), .RX_MBOX_OFF(EXP[3]), .TX_MBOX_OFF(EXP[4]),
    .EX_MBOX_OFF(EXP[5]), .STATS_OFF(EXP[6]), .MEM_KBYTES(EXP[7]),
    .BD_REGION_BYTES(EXP[8]), .TX_LIST_START(EXP[9]), .TX_LIST_COUNT(EXP[10]),
    .RX_LIST_START(EXP[11]), .RX_LIST_COUNT(EXP[12]), .FW_REVISION(EXP[13]),
    .CTRL_STATS_OFF(EXP[15])) i_acr_top (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .hostIrq(hostIrq));
  acr_host_model i_acr_host_model (.sys_clk(sys_clk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hangSeen(hangSeen));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkIrq(input logic e);
    n_compared++;
    if (hostIrq !== e) begin
      miscompares++;
      $display("CHECK FAILED hostIrq expected %b seen %b", e, hostIrq);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_acr_host_model.xfer(1'b1, a, d, r);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    i_acr_host_model.xfer(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  // Poll under a bound; running out ends the run
  task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int n;
    n = 0;
    do begin
      i_acr_host_model.xfer(1'b0, a, 32'h0000_0000, q);
      n++;
    end while ((q & m) !== v && n < 40);
    chk(nm, v, q & m);
    if ((q & m) !== v) test_done();
  endtask
  always @(posedge hangSeen) begin
    miscompares++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    poll("auto header", `ACR_ADDR_PRAM, 32'h0000_8000, 32'h0000_8000);
    for (int k = 1; k <= 16; k++) begin
      rc("block word", `ACR_ADDR_PRAM + 8'(4*k), 32'(EXP[k]));
    end
    rc("irq stat", `ACR_ADDR_IRQ_STAT, 32'h0000_0002);
    rc("cmd out", `ACR_ADDR_CMD_OUT, 32'h0000_0000);
    chkIrq(1'b0);
    wr(8'h30, 32'h0000_FFFF);
    rc("unmapped", 8'h30, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, 32'(hresp));
    $display("test auto report done");
    // Corrupt one block word; the command must rewrite it
    wr(`ACR_ADDR_PRAM + 8'h14, 32'h0000_BEEF);
    wr(`ACR_ADDR_PRAM, 32'h0000_0006);
    wr(`ACR_ADDR_IRQ_EN, 32'h0000_0001);
    wr(`ACR_ADDR_HOST_CTRL, 32'h0000_0001);
    wr(`ACR_ADDR_CMD_IN, 32'h0000_0006);
    poll("header", `ACR_ADDR_PRAM, 32'h0000_FFFF, 32'h0000_8006);
    rc("block word", `ACR_ADDR_PRAM + 8'h14, 32'(EXP[5]));
    rc("cmd out", `ACR_ADDR_CMD_OUT, 32'h0000_0008);
    rc("irq stat", `ACR_ADDR_IRQ_STAT, 32'h0000_0003);
    chkIrq(1'b1);
    wr(`ACR_ADDR_IRQ_CLR, 32'h0000_0007);
    rc("irq stat", `ACR_ADDR_IRQ_STAT, 32'h0000_0000);
    chkIrq(1'b0);
    $display("test report command done");
    wr(`ACR_ADDR_PRAM, 32'h0000_0007);
    wr(`ACR_ADDR_CMD_IN, 32'h0000_0007);
    poll("header", `ACR_ADDR_PRAM, 32'h0000_FFFF, 32'h0000_8007);
    foreach (ECHO[i]) begin
      wr(`ACR_ADDR_IRQ_CLR, 32'h0000_0007);
      wr(`ACR_ADDR_CMD_IN, 32'(ECHO[i]));
      rc("echo", `ACR_ADDR_CMD_OUT, 32'(ECHO[i]));
      rc("irq stat", `ACR_ADDR_IRQ_STAT, 32'h0000_0005);
      chkIrq(1'b1);
    end
    // Host enable off: echo still lands but the pin stays quiet
    wr(`ACR_ADDR_IRQ_CLR, 32'h0000_0007);
    wr(`ACR_ADDR_HOST_CTRL, 32'h0000_0000);
    wr(`ACR_ADDR_CMD_IN, 32'h0000_0042);
    rc("echo", `ACR_ADDR_CMD_OUT, 32'h0000_0042);
    chkIrq(1'b0);
    $display("test wrap done");
    // An execute code and attention alone do not leave wrap
    wr(`ACR_ADDR_PRAM, 32'h0000_0006);
    wr(`ACR_ADDR_CMD_IN, 32'h0000_0006);
    rc("echo", `ACR_ADDR_CMD_OUT, 32'h0000_0006);
    rc("header", `ACR_ADDR_PRAM, 32'h0000_0006);
    wr(`ACR_ADDR_HOST_CTRL, 32'h0000_0002);
    wr(`ACR_ADDR_CMD_IN, 32'h0000_1234);
    rc("echo", `ACR_ADDR_CMD_OUT, 32'h0000_1234);
    wr(`ACR_ADDR_HOST_CTRL, 32'h0000_0006);
    poll("header", `ACR_ADDR_PRAM, 32'h0000_8000, 32'h0000_8000);
    rc("cmd out", `ACR_ADDR_CMD_OUT, 32'h0000_0000);
    wr(`ACR_ADDR_CMD_IN, 32'h0000_2222);
    poll("ack", `ACR_ADDR_CMD_OUT, 32'h0000_FFFF, 32'h0000_0008);
    $display("test wrap end done");
    wr(`ACR_ADDR_PRAM, 32'h0000_0005);
    wr(`ACR_ADDR_CMD_IN, 32'h0000_0001);
    poll("error header", `ACR_ADDR_PRAM, 32'h0000_FFFF, 32'h0000_A005);
    $display("test unknown code done");
    test_done();
  end
endmodule
`default_nettype wire
